// File: verilog/lpmc_pkg.sv
// package: shared constants and types of the low power mode controller
package lpmc_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] TBCTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // system_control_two field positions
  localparam int FAST_OSC_BIT  = 7;
  localparam int SLOW_OSC_BIT  = 6;
  localparam int CLK_SEL_BIT   = 5;
  localparam int HALT_REQ_BIT  = 4;
  localparam int GATE_REQ_BIT  = 2;

  // base_timer_control field positions
  localparam int TB_EN_BIT     = 7;
  localparam int TB_SEL_LSB    = 0;
  localparam int TB_SEL_W      = 3;
  localparam int TB_TAPS       = 8;

  // status field positions
  localparam int ST_MODE_LSB   = 0;
  localparam int ST_STBY_LSB   = 4;

  // reset values
  localparam logic       FAST_OSC_RST = 1'b1;
  localparam logic       SLOW_OSC_RST = 1'b0;
  localparam logic       CLK_SEL_RST  = 1'b0;
  localparam logic       TB_EN_RST    = 1'b0;
  localparam logic [2:0] TB_SEL_RST   = 3'h0;

  typedef enum logic [2:0] {
    FAST_SINGLE_CLOCK_RUN,
    FAST_DUAL_CLOCK_RUN,
    LOW_CLOCK_RUN_FAST_OFF,
    LOW_CLOCK_RUN_FAST_ON,
    CORE_HALT_FAST_CLOCK,
    CORE_HALT_LOW_CLOCK,
    BASE_TIMER_ONLY_FAST,
    BASE_TIMER_ONLY_LOW
  } lpmc_mode_e;

  typedef enum logic [1:0] {
    STBY_RUN,
    STBY_HALT,
    STBY_TBONLY
  } lpmc_stby_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } lpmc_apb_req_s;

  // wake inputs from the interrupt logic
  typedef struct packed {
    logic masterIntEn;
    logic wakeReq;
    logic baseTimerEnFlag;
    logic watchdogIrq;
  } lpmc_core_s;

endpackage

// File: verilog/lpmc_tap_edge.sv
// module: falling edge detector on the selected base timer source tap
`timescale 1ns/1ps
module lpmc_tap_edge (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  // taps
  input  wire logic [lpmc_pkg::TB_TAPS-1:0]  taps,
  input  wire logic [lpmc_pkg::TB_SEL_W-1:0] sel,
  // result
  output logic                               fall
);

  logic tapNow;
  logic tap_r;

  assign tapNow = taps[sel];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tap_r <= 1'b0;
    end else if (ce) begin
      tap_r <= tapNow;
    end
  end

  assign fall = ce && tap_r && !tapNow;

endmodule

// File: verilog/lpmc_wake_sel.sv
// module: release and vectoring decision for the standby states
`timescale 1ns/1ps
module lpmc_wake_sel (
  // state
  input  wire lpmc_pkg::lpmc_stby_e stby,
  input  wire lpmc_pkg::lpmc_core_s core,
  input  wire logic                 tbFall,
  input  wire logic                 tbEn,
  // decision
  output logic                      release_o,
  output logic                      vector,
  output logic                      tbVector
);

  logic tbIrqPath;

  assign tbIrqPath = core.masterIntEn && core.baseTimerEnFlag && tbEn;

  always_comb begin
    release_o = 1'b0;
    vector    = 1'b0;
    tbVector  = 1'b0;
    case (stby)
      lpmc_pkg::STBY_HALT: begin
        release_o = core.wakeReq;
        vector    = core.wakeReq && core.masterIntEn;
      end
      lpmc_pkg::STBY_TBONLY: begin
        release_o = tbFall;
        tbVector  = tbFall && tbIrqPath;
      end
      default: begin
        release_o = 1'b0;
      end
    endcase
  end

endmodule

// File: verilog/lpmc_mode_ctrl.sv
// module: standby and low clock mode controller with apb registers
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module lpmc_mode_ctrl (
  // clock, reset, clock enable
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  // interrupt logic and core
  input  wire logic                          masterIntEn,
  input  wire logic                          wakeReq,
  input  wire logic                          baseTimerEnFlag,
  input  wire logic                          watchdogIrq,
  input  wire logic [lpmc_pkg::TB_TAPS-1:0]  baseTimerTaps,
  // clock and hold controls
  output logic                               cpuRun,
  output logic                               watchdogRun,
  output logic                               periphClkEn,
  output logic                               baseTimerClkEn,
  output logic                               stateHold,
  output logic                               pcHold,
  // oscillators and clock select
  output logic                               fastOscEn,
  output logic                               slowOscEn,
  output logic                               sysClkSel,
  // wake events
  output logic                               baseTimerIrqSet,
  output logic                               wakeResume,
  output logic                               wakeVector,
  output logic                               wakeTbVector,
  // mode
  output lpmc_pkg::lpmc_mode_e               mode
);

  lpmc_pkg::lpmc_apb_req_s req;
  lpmc_pkg::lpmc_core_s    core;
  lpmc_pkg::lpmc_stby_e    stby_r;
  lpmc_pkg::lpmc_mode_e    mode_r;

  logic                          fastOsc_r;
  logic                          slowOsc_r;
  logic                          clkSel_r;
  logic                          haltReq_r;
  logic                          gateReq_r;
  logic                          tbEn_r;
  logic [lpmc_pkg::TB_SEL_W-1:0] tbSel_r;
  logic [31:0]                   prdata_r;
  logic                          tbIrqSet_r;
  logic                          wakeResume_r;
  logic                          wakeVector_r;
  logic                          wakeTbVector_r;

  logic        apbSetup;
  logic        apbWrite;
  logic        wrCtrl;
  logic        wrTb;
  logic        mapped;
  logic        enterHalt;
  logic        enterGate;
  logic        tbFall;
  logic        release_w;
  logic        vector_w;
  logic        tbVector_w;
  logic [31:0] rdValue;

  // decoding used by the slave error answer; the read path decodes paddr in its own case
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == lpmc_pkg::CTRL_OFS) || (a == lpmc_pkg::TBCTRL_OFS)
            || (a == lpmc_pkg::STATUS_OFS);
  endfunction

  // operating mode from standby state and clock settings
  function automatic lpmc_pkg::lpmc_mode_e modeOf(
    input lpmc_pkg::lpmc_stby_e s,
    input logic                 lowClk,
    input logic                 fastOn,
    input logic                 slowOn
  );
    case (s)
      lpmc_pkg::STBY_HALT: begin
        modeOf = lowClk ? lpmc_pkg::CORE_HALT_LOW_CLOCK : lpmc_pkg::CORE_HALT_FAST_CLOCK;
      end
      lpmc_pkg::STBY_TBONLY: begin
        modeOf = lowClk ? lpmc_pkg::BASE_TIMER_ONLY_LOW : lpmc_pkg::BASE_TIMER_ONLY_FAST;
      end
      default: begin
        if (lowClk) begin
          modeOf = fastOn ? lpmc_pkg::LOW_CLOCK_RUN_FAST_ON
                          : lpmc_pkg::LOW_CLOCK_RUN_FAST_OFF;
        end else begin
          modeOf = slowOn ? lpmc_pkg::FAST_DUAL_CLOCK_RUN
                          : lpmc_pkg::FAST_SINGLE_CLOCK_RUN;
        end
      end
    endcase
  endfunction

  assign req  = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign core = '{masterIntEn: masterIntEn, wakeReq: wakeReq,
                  baseTimerEnFlag: baseTimerEnFlag, watchdogIrq: watchdogIrq};

  // zero wait state slave: read data is captured in the setup cycle
  assign apbSetup = req.psel && !req.penable;
  assign apbWrite = req.psel && req.penable && req.pwrite && ce;
  assign mapped   = isMapped(req.paddr);
  assign wrCtrl   = apbWrite && (req.paddr == lpmc_pkg::CTRL_OFS);
  assign wrTb     = apbWrite && (req.paddr == lpmc_pkg::TBCTRL_OFS);
  assign pready   = 1'b1;
  assign pslverr  = req.psel && req.penable && !mapped;

  // halt wins if both requests arrive together; a pending watchdog
  // interrupt blocks either entry so the core can service it first
  assign enterHalt = wrCtrl && (stby_r == lpmc_pkg::STBY_RUN)
                  && req.pwdata[lpmc_pkg::HALT_REQ_BIT] && !core.watchdogIrq;
  assign enterGate = wrCtrl && (stby_r == lpmc_pkg::STBY_RUN)
                  && req.pwdata[lpmc_pkg::GATE_REQ_BIT]
                  && !req.pwdata[lpmc_pkg::HALT_REQ_BIT] && !core.watchdogIrq;

  // the tap is sampled on clk_sys, so the exit lands on the next edge
  // after the source falls and the stay can undercut the nominal period
  lpmc_tap_edge lpmc_tap_edge_inst (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .taps    (baseTimerTaps),
    .sel     (tbSel_r),
    .fall    (tbFall)
  );

  lpmc_wake_sel lpmc_wake_sel_inst (
    .stby      (stby_r),
    .core      (core),
    .tbFall    (tbFall),
    .tbEn      (tbEn_r),
    .release_o (release_w),
    .vector    (vector_w),
    .tbVector  (tbVector_w)
  );

  always_comb begin
    rdValue = 32'h0000_0000;
    case (req.paddr)
      lpmc_pkg::CTRL_OFS: begin
        rdValue[lpmc_pkg::FAST_OSC_BIT] = fastOsc_r;
        rdValue[lpmc_pkg::SLOW_OSC_BIT] = slowOsc_r;
        rdValue[lpmc_pkg::CLK_SEL_BIT]  = clkSel_r;
        rdValue[lpmc_pkg::HALT_REQ_BIT] = haltReq_r;
        rdValue[lpmc_pkg::GATE_REQ_BIT] = gateReq_r;
      end
      lpmc_pkg::TBCTRL_OFS: begin
        rdValue[lpmc_pkg::TB_EN_BIT] = tbEn_r;
        rdValue[lpmc_pkg::TB_SEL_LSB +: lpmc_pkg::TB_SEL_W] = tbSel_r;
      end
      lpmc_pkg::STATUS_OFS: begin
        rdValue[lpmc_pkg::ST_MODE_LSB +: 3] = mode_r;
        rdValue[lpmc_pkg::ST_STBY_LSB +: 2] = stby_r;
      end
      default: begin
        rdValue = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prdata_r <= 32'h0000_0000;
    end else if (ce && apbSetup) begin
      prdata_r <= rdValue;
    end
  end

  // oscillator and clock source settings; sequencing them is software's job
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fastOsc_r <= lpmc_pkg::FAST_OSC_RST;
      slowOsc_r <= lpmc_pkg::SLOW_OSC_RST;
      clkSel_r  <= lpmc_pkg::CLK_SEL_RST;
    end else if (wrCtrl) begin
      fastOsc_r <= req.pwdata[lpmc_pkg::FAST_OSC_BIT];
      slowOsc_r <= req.pwdata[lpmc_pkg::SLOW_OSC_BIT];
      clkSel_r  <= req.pwdata[lpmc_pkg::CLK_SEL_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tbEn_r  <= lpmc_pkg::TB_EN_RST;
      tbSel_r <= lpmc_pkg::TB_SEL_RST;
    end else if (wrTb) begin
      tbEn_r  <= req.pwdata[lpmc_pkg::TB_EN_BIT];
      tbSel_r <= req.pwdata[lpmc_pkg::TB_SEL_LSB +: lpmc_pkg::TB_SEL_W];
    end
  end

  // standby state; release returns to the run mode kept in the clock bits
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stby_r <= lpmc_pkg::STBY_RUN;
    end else if (ce) begin
      case (stby_r)
        lpmc_pkg::STBY_RUN: begin
          if (enterHalt) begin
            stby_r <= lpmc_pkg::STBY_HALT;
          end else if (enterGate) begin
            stby_r <= lpmc_pkg::STBY_TBONLY;
          end
        end
        lpmc_pkg::STBY_HALT: begin
          if (release_w) begin
            stby_r <= lpmc_pkg::STBY_RUN;
          end
        end
        lpmc_pkg::STBY_TBONLY: begin
          if (release_w) begin
            stby_r <= lpmc_pkg::STBY_RUN;
          end
        end
        default: begin
          stby_r <= lpmc_pkg::STBY_RUN;
        end
      endcase
    end
  end

  // request bits read back set while in standby and clear on release
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      haltReq_r <= 1'b0;
      gateReq_r <= 1'b0;
    end else if (ce) begin
      if (enterHalt) begin
        haltReq_r <= 1'b1;
      end else if (release_w && stby_r == lpmc_pkg::STBY_HALT) begin
        haltReq_r <= 1'b0;
      end
      if (enterGate) begin
        gateReq_r <= 1'b1;
      end else if (release_w && stby_r == lpmc_pkg::STBY_TBONLY) begin
        gateReq_r <= 1'b0;
      end
    end
  end

  // wake events go to the core as one cycle pulses
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tbIrqSet_r     <= 1'b0;
      wakeResume_r   <= 1'b0;
      wakeVector_r   <= 1'b0;
      wakeTbVector_r <= 1'b0;
    end else if (ce) begin
      tbIrqSet_r     <= enterGate && tbEn_r;
      wakeResume_r   <= release_w && !vector_w && !tbVector_w;
      wakeVector_r   <= vector_w;
      wakeTbVector_r <= tbVector_w;
    end
  end

  // the variant tracks the clock source held during the stay
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mode_r <= lpmc_pkg::FAST_SINGLE_CLOCK_RUN;
    end else if (ce) begin
      mode_r <= modeOf(stby_r, clkSel_r, fastOsc_r, slowOsc_r);
    end
  end

  assign prdata          = prdata_r;
  assign cpuRun          = (stby_r == lpmc_pkg::STBY_RUN);
  assign watchdogRun     = (stby_r != lpmc_pkg::STBY_HALT);
  assign periphClkEn     = (stby_r != lpmc_pkg::STBY_TBONLY);
  assign baseTimerClkEn  = 1'b1;
  // the core freezes fetch, registers and latches while this is high
  assign stateHold       = (stby_r != lpmc_pkg::STBY_RUN);
  assign pcHold          = (stby_r != lpmc_pkg::STBY_RUN);
  assign fastOscEn       = fastOsc_r;
  assign slowOscEn       = slowOsc_r;
  assign sysClkSel       = clkSel_r;
  assign baseTimerIrqSet = tbIrqSet_r;
  assign wakeResume      = wakeResume_r;
  assign wakeVector      = wakeVector_r;
  assign wakeTbVector    = wakeTbVector_r;
  assign mode            = mode_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_halt_stops_core: assert property (
    stby_r == lpmc_pkg::STBY_HALT |-> !cpuRun && !watchdogRun && periphClkEn)
    else $error("core or watchdog running in halt");
  chk_standby_holds: assert property (
    stby_r != lpmc_pkg::STBY_RUN |-> stateHold && !cpuRun)
    else $error("state not held in standby");
  chk_pc_hold: assert property (
    $rose(pcHold) |-> $past(enterHalt) || $past(enterGate))
    else $error("pc hold without entry");
  chk_halt_autoclear: assert property (
    stby_r == lpmc_pkg::STBY_HALT && core.wakeReq && ce
      |=> !haltReq_r && stby_r == lpmc_pkg::STBY_RUN)
    else $error("halt request not cleared on release");
  chk_reset_run: assert property (disable iff (1'b0)
    !rst_b |=> mode_r == lpmc_pkg::FAST_SINGLE_CLOCK_RUN && stby_r == lpmc_pkg::STBY_RUN)
    else $error("reset did not return to fast single run");
  chk_plain_wake: assert property (
    stby_r == lpmc_pkg::STBY_HALT && core.wakeReq && !core.masterIntEn && ce
      |=> wakeResume && !wakeVector)
    else $error("normal release vectored");
  chk_vector_wake: assert property (
    stby_r == lpmc_pkg::STBY_HALT && core.wakeReq && core.masterIntEn && ce
      |=> wakeVector && !wakeResume)
    else $error("interrupt release not vectored");
  chk_wdt_blocks: assert property (
    wrCtrl && req.pwdata[lpmc_pkg::HALT_REQ_BIT] && core.watchdogIrq && ce
      && stby_r == lpmc_pkg::STBY_RUN |=> stby_r == lpmc_pkg::STBY_RUN)
    else $error("standby entered over watchdog interrupt");
  chk_tb_gating: assert property (
    stby_r == lpmc_pkg::STBY_TBONLY |-> !periphClkEn && baseTimerClkEn && watchdogRun)
    else $error("peripheral clock not gated");
  // the pulse may only stretch when the enable was low at the edge that would end it
  chk_tb_latch: assert property (
    enterGate && tbEn_r && ce |=> baseTimerIrqSet ##1 (!baseTimerIrqSet || !$past(ce)))
    else $error("base timer latch not set at entry");
  chk_tb_release: assert property (
    stby_r == lpmc_pkg::STBY_TBONLY && tbFall |=> stby_r == lpmc_pkg::STBY_RUN
      && !gateReq_r && (wakeTbVector || wakeResume))
    else $error("falling edge did not release");

  cov_halt_vector: cover property (
    stby_r == lpmc_pkg::STBY_HALT ##1 wakeVector);
  cov_tb_service: cover property (
    stby_r == lpmc_pkg::STBY_TBONLY ##1 wakeTbVector);
  cov_low_halt: cover property (mode_r == lpmc_pkg::CORE_HALT_LOW_CLOCK);

endmodule

// File: dv/lpmc_core_model.sv
// partner model: interrupt logic of the core and the base timer divider
`timescale 1ns/1ps
module lpmc_core_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // software side
  input  wire logic       imeSet,
  input  wire logic [1:0] wakeEnSet,
  input  wire logic       srcFire,
  input  wire logic       latchClr,
  input  wire logic       wdFire,
  input  wire logic       tapRun,
  // device side
  input  wire logic       baseTimerIrqSet,
  output logic            masterIntEn,
  output logic            wakeReq,
  output logic            baseTimerEnFlag,
  output logic            watchdogIrq,
  output logic [7:0]      baseTimerTaps
);
  // latch bit 0 is a generic source, bit 1 the base timer
  logic [1:0] latch_r;
  logic [7:0] tapCnt_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_b || latchClr) begin
      latch_r <= 2'h0;
    end else begin
      if (srcFire)
        latch_r[0] <= 1'b1;
      if (baseTimerIrqSet)
        latch_r[1] <= 1'b1;
    end
  end

  // the divider may stall so a scenario can hold the selected tap still
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tapCnt_r <= 8'h00;
    end else if (tapRun) begin
      tapCnt_r <= tapCnt_r + 8'h01;
    end
  end

  assign masterIntEn     = imeSet;
  assign baseTimerEnFlag = wakeEnSet[1];
  assign watchdogIrq     = wdFire;
  assign wakeReq         = |(latch_r & wakeEnSet);
  assign baseTimerTaps   = tapCnt_r;
endmodule

// File: dv/lpmc_mode_ctrl_tb_top.sv
// testbench: walks the mode controller through its run and standby modes except BASE_TIMER_ONLY_LOW
`timescale 1ns/1ps
module lpmc_mode_ctrl_tb_top;
  localparam logic [7:0] CtrlA = lpmc_pkg::CTRL_OFS;
  localparam logic [7:0] TbA   = lpmc_pkg::TBCTRL_OFS;
  localparam logic [7:0] StA   = lpmc_pkg::STATUS_OFS;
  logic                 clk_sys, rst_b, ce, psel, penable, pwrite;
  logic [7:0]           paddr, baseTimerTaps;
  logic [31:0]          pwdata, prdata;
  logic                 pready, pslverr, masterIntEn, wakeReq, baseTimerEnFlag, watchdogIrq;
  logic                 cpuRun, watchdogRun, periphClkEn, baseTimerClkEn, stateHold, pcHold;
  logic                 fastOscEn, slowOscEn, sysClkSel, baseTimerIrqSet;
  logic                 wakeResume, wakeVector, wakeTbVector;
  lpmc_pkg::lpmc_mode_e mode;
  logic                 imeSet, srcFire, latchClr, wdFire, tapRun;
  logic [1:0]           wakeEnSet;
  logic [4:0]           ctlVec;
  int                   errors, totalChecks, cycles, nRes, nVec, nTbv, nSet;

  assign ctlVec = {cpuRun, watchdogRun, periphClkEn, stateHold, pcHold};

  lpmc_mode_ctrl lpmc_mode_ctrl_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .masterIntEn(masterIntEn), .wakeReq(wakeReq),
    .baseTimerEnFlag(baseTimerEnFlag), .watchdogIrq(watchdogIrq),
    .baseTimerTaps(baseTimerTaps), .cpuRun(cpuRun), .watchdogRun(watchdogRun),
    .periphClkEn(periphClkEn), .baseTimerClkEn(baseTimerClkEn), .stateHold(stateHold),
    .pcHold(pcHold), .fastOscEn(fastOscEn), .slowOscEn(slowOscEn), .sysClkSel(sysClkSel),
    .baseTimerIrqSet(baseTimerIrqSet), .wakeResume(wakeResume), .wakeVector(wakeVector),
    .wakeTbVector(wakeTbVector), .mode(mode));

  lpmc_core_model lpmc_core_model_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .imeSet(imeSet), .wakeEnSet(wakeEnSet), .srcFire(srcFire),
    .latchClr(latchClr), .wdFire(wdFire), .tapRun(tapRun),
    .baseTimerIrqSet(baseTimerIrqSet), .masterIntEn(masterIntEn), .wakeReq(wakeReq),
    .baseTimerEnFlag(baseTimerEnFlag), .watchdogIrq(watchdogIrq),
    .baseTimerTaps(baseTimerTaps));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // one-cycle event pulses are tallied mid-cycle, away from the driving edge
  always @(negedge clk_sys) begin
    if (wakeResume === 1'b1) nRes++;
    if (wakeVector === 1'b1) nVec++;
    if (wakeTbVector === 1'b1) nTbv++;
    if (baseTimerIrqSet === 1'b1) nSet++;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("[FAIL] %0t run did not complete", $time);
      finish_test;
    end
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe, input string m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, m);
    chk({31'h0, e}, {31'h0, xe}, "slave error");
  endtask

  task automatic pulses(input int r, input int v, input int t, input int s);
    chk(nRes, r, "resume pulses");
    chk(nVec, v, "vector pulses");
    chk(nTbv, t, "timer vector pulses");
    chk(nSet, s, "latch set pulses");
    {nRes, nVec, nTbv, nSet} = '0;
  endtask

  task automatic clr_latch;
    latchClr <= 1'b1;
    @(posedge clk_sys);
    latchClr <= 1'b0;
  endtask

  task automatic t_after_reset;
    chk({ctlVec, baseTimerClkEn, fastOscEn, slowOscEn, sysClkSel}, 9'h1cc, "reset pins");
    chk(mode, lpmc_pkg::FAST_SINGLE_CLOCK_RUN, "reset mode");
    rdc(CtrlA, 32'h80, 1'b0, "control reset");
    rdc(TbA, 32'h0, 1'b0, "timer control reset");
    wr(StA, 32'hff);
    rdc(StA, 32'h0, 1'b0, "status read only");
    wr(8'h0c, 32'hff);
    rdc(8'h0c, 32'h0, 1'b1, "unmapped read");
    rdc(CtrlA, 32'h80, 1'b0, "unmapped write ignored");
    pulses(0, 0, 0, 0);
  endtask

  task automatic halt_cycle(input logic [7:0] run, input logic ime,
                            input lpmc_pkg::lpmc_mode_e hm, input lpmc_pkg::lpmc_mode_e rm);
    int i;
    imeSet <= 1'b0;
    @(posedge clk_sys);
    wakeEnSet <= 2'h1;
    imeSet    <= ime;
    wr(CtrlA, {24'h0, run | 8'h10});
    repeat (2) @(posedge clk_sys);
    chk(ctlVec, 5'h07, "halt controls");
    chk(mode, hm, "halt mode");
    rdc(StA, {26'h0, 2'h1, 1'b0, hm}, 1'b0, "halt status");
    srcFire <= 1'b1;
    @(posedge clk_sys);
    srcFire <= 1'b0;
    for (i = 0; i < 20 && cpuRun !== 1'b1; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    chk(ctlVec, 5'h1c, "halt release");
    chk(mode, rm, "mode after halt");
    pulses(!ime, ime, 0, 0);
    rdc(CtrlA, {24'h0, run}, 1'b0, "halt request cleared");
    clr_latch;
    wakeEnSet <= 2'h0;
  endtask

  task automatic t_wd_block;
    wdFire <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(CtrlA, k ? 32'h84 : 32'h90);
      repeat (2) @(posedge clk_sys);
      chk(ctlVec, 5'h1c, "entry blocked");
      rdc(CtrlA, 32'h80, 1'b0, "requests stay clear");
    end
    wdFire <= 1'b0;
  endtask

  // a write while the clock enable is low must leave every request untouched
  task automatic t_ce_freeze;
    ce <= 1'b0;
    wr(CtrlA, 32'h90);
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(ctlVec, 5'h1c, "frozen write entered halt");
    rdc(CtrlA, 32'h80, 1'b0, "control changed while frozen");
  endtask

  task automatic tb_only(input logic [7:0] tbc, input logic ime, input logic vec);
    int i;
    imeSet    <= ime;
    wakeEnSet <= 2'h2;
    tapRun    <= 1'b0;
    wr(TbA, {24'h0, tbc});
    wr(CtrlA, 32'h84);
    repeat (2) @(posedge clk_sys);
    chk({ctlVec[2:0], baseTimerClkEn}, 4'h7, "gated controls");
    chk(mode, lpmc_pkg::BASE_TIMER_ONLY_FAST, "timer-only mode");
    repeat (20) @(posedge clk_sys);
    chk(periphClkEn, 1'b0, "no release while tap is still");
    tapRun <= 1'b1;
    for (i = 0; i < 40 && periphClkEn !== 1'b1; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    tapRun <= 1'b0;
    chk(ctlVec, 5'h1c, "timer-only release");
    pulses(!vec, 0, vec, tbc[7]);
    rdc(CtrlA, 32'h80, 1'b0, "gate request cleared");
    clr_latch;
  endtask

  task automatic t_low_clock;
    logic [7:0]           seq [3] = '{8'hc0, 8'he0, 8'h60};
    lpmc_pkg::lpmc_mode_e ms [3] = '{lpmc_pkg::FAST_DUAL_CLOCK_RUN,
                                     lpmc_pkg::LOW_CLOCK_RUN_FAST_ON,
                                     lpmc_pkg::LOW_CLOCK_RUN_FAST_OFF};
    for (int k = 0; k < 3; k++) begin
      wr(CtrlA, {24'h0, seq[k]});
      repeat (2) @(posedge clk_sys);
      chk(mode, ms[k], "run mode");
      chk({fastOscEn, slowOscEn, sysClkSel}, seq[k][7:5], "clock controls");
    end
    halt_cycle(8'h60, 1'b1, lpmc_pkg::CORE_HALT_LOW_CLOCK,
               lpmc_pkg::LOW_CLOCK_RUN_FAST_OFF);
  endtask

  task automatic t_reset_in_halt;
    wr(CtrlA, 32'h70);
    repeat (2) @(posedge clk_sys);
    chk(cpuRun, 1'b0, "halted before reset");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(ctlVec, 5'h1c, "reset releases halt");
    chk(mode, lpmc_pkg::FAST_SINGLE_CLOCK_RUN, "mode after reset");
    rdc(CtrlA, 32'h80, 1'b0, "control after reset");
  endtask

  initial begin
    {rst_b, psel, penable, pwrite, imeSet, srcFire, latchClr, wdFire, tapRun} = '0;
    {paddr, pwdata, wakeEnSet} = '0;
    ce = 1'b1;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_after_reset;
    halt_cycle(8'h80, 1'b0, lpmc_pkg::CORE_HALT_FAST_CLOCK,
               lpmc_pkg::FAST_SINGLE_CLOCK_RUN);
    t_wd_block;
    t_ce_freeze;
    tb_only(8'h83, 1'b1, 1'b1);
    tb_only(8'h03, 1'b1, 1'b0);
    tb_only(8'h82, 1'b0, 1'b0);
    t_low_clock;
    t_reset_in_halt;
    finish_test;
  end
endmodule
